// ==== verilog/lto_pkg.sv ====
// Purpose: Shared constants and types for the literal and table opcode decoder
// Assumes: One core clock, four clocks per instruction cycle
// Notes:   Register offsets are byte addresses on the plain register port
package lto_pkg;

  // ---------------------------------------------------------------
  // Widths
  // ---------------------------------------------------------------
  localparam int unsigned DATA_W   = 8;
  localparam int unsigned ADDR_W   = 12;
  localparam int unsigned WORD_W   = 16;
  localparam int unsigned PROD_W   = 16;
  localparam int unsigned TBL_W    = 22;
  localparam int unsigned BANK_W   = 4;
  localparam int unsigned BUS_AW   = 8;
  localparam int unsigned BUS_DW   = 32;
  localparam int unsigned FSR_CNT  = 3;

  // ---------------------------------------------------------------
  // Opcode fields
  // ---------------------------------------------------------------
  localparam logic [7:0] OPC_ADD_LIT   = 8'h0f;
  localparam logic [7:0] OPC_AND_LIT   = 8'h0b;
  localparam logic [7:0] OPC_OR_LIT    = 8'h09;
  localparam logic [7:0] OPC_XOR_LIT   = 8'h0a;
  localparam logic [7:0] OPC_SUB_LIT   = 8'h08;
  localparam logic [7:0] OPC_LOAD_LIT  = 8'h0e;
  localparam logic [7:0] OPC_MUL_LIT   = 8'h0d;
  localparam logic [7:0] OPC_RET_LIT   = 8'h0c;
  localparam logic [11:0] OPC_BANK_HI  = 12'h010;
  localparam logic [11:0] OPC_TABLE_HI = 12'h000;
  localparam logic [9:0] OPC_PTR_HI    = 10'h3b8;
  localparam logic [7:0] OPC_PTR2_HI   = 8'hf0;
  localparam logic [5:0] OPC_ADD_W_FILE_OP_HI  = 6'h09;

  // Table pointer update modes (low two bits)
  localparam logic [1:0] TBL_PLAIN    = 2'h0;
  localparam logic [1:0] TBL_POST_INC = 2'h1;
  localparam logic [1:0] TBL_POST_DEC = 2'h2;
  localparam logic [1:0] TBL_PRE_INC  = 2'h3;

  // ---------------------------------------------------------------
  // Data addressing
  // ---------------------------------------------------------------
  localparam logic [7:0] ACCESS_SPLIT = 8'h60;
  localparam logic [7:0] INDEX_LIMIT  = 8'h5f;
  localparam logic [3:0] ACCESS_HIGH  = 4'hf;
  localparam int unsigned INDEX_PTR   = 2;

  // ---------------------------------------------------------------
  // Register port map and reset values
  // ---------------------------------------------------------------
  localparam logic [7:0] REG_CTRL    = 8'h00;
  localparam logic [7:0] REG_W       = 8'h04;
  localparam logic [7:0] REG_STATUS  = 8'h08;
  localparam logic [7:0] REG_BANK    = 8'h0c;
  localparam logic [7:0] REG_PROD    = 8'h10;
  localparam logic [7:0] REG_FSR0    = 8'h14;
  localparam logic [7:0] REG_FSR1    = 8'h18;
  localparam logic [7:0] REG_FSR2    = 8'h1c;
  localparam logic [7:0] REG_TBLPTR  = 8'h20;
  localparam int unsigned CTRL_EXT_BIT = 0;
  localparam int unsigned CTRL_PSA_BIT = 1;
  localparam logic [1:0]  CTRL_RST     = 2'h0;
  localparam logic [7:0]  W_RST        = 8'h00;
  localparam logic [3:0]  BANK_RST     = 4'h0;

  // ---------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {LTO_Q1, LTO_Q2, LTO_Q3, LTO_Q4} lto_q_t;
  typedef enum logic {LTO_CYC_FIRST, LTO_CYC_SECOND} lto_cyc_t;

  typedef struct packed {
    logic n;
    logic ov;
    logic z;
    logic dc;
    logic c;
  } lto_flags_t;

  typedef struct packed {
    logic              en;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
  } lto_file_wr_t;

  typedef struct packed {
    logic [BUS_AW-1:0] addr;
    logic [BUS_DW-1:0] wdata;
    logic              wr;
    logic              rd;
  } lto_bus_req_t;

endpackage

// ==== verilog/lto_decoder.sv ====
// Purpose: Literal, table and add-W-to-file opcode decode and execute
// Assumes: Program memory presents the next word during Q1 of each cycle
// Notes:   Data memory reads combinationally from file_rd_addr
//
// Function
// [RULE1] Add literal to W, store in W, update C DC Z OV N, one cycle.
// [RULE2] AND literal into W in one cycle, updating only Z and N.
// [RULE3] OR literal into W in one cycle, updating only Z and N.
// [RULE4] XOR literal into W in one cycle, updating only Z and N.
// [RULE5] Literal minus W into W, one cycle, update C DC Z OV N.
// [RULE6] Load literal into W in one cycle, flags untouched.
// [RULE7] Load four-bit literal into bank select low bits, no flag change.
// [RULE8] Multiply literal by W in one cycle, flags untouched.
// [RULE9] Load literal into W and return, two cycles, flags untouched.
// [RULE10] Two-word pointer load writes 12-bit literal to chosen pointer, two cycles.
// [RULE11] Table reads with four pointer update modes, two cycles, no flags.
// [RULE12] Table writes with four pointer update modes, two cycles, no flags.
// [RULE13] Add W to file f, result to W or f by d, update all flags.
// [RULE14] Bit a clear selects access bank; set selects bank from bank register.
// [RULE15] Extended set, a clear, f up to 5Fh: indexed literal offset access.
// [RULE16] Decode Q1, read f Q2, process Q3, write destination Q4.
// [RULE17] Program counter change makes two cycles, second one a no-operation.
// [RULE18] Lone second word of two-word instruction executes as no-operation.
// [RULE19] Port read-modify-write reads pin levels, not output latch.
// [RULE20] Writing timer-zero count clears its prescaler when assigned.
`timescale 1ns/1ps

module lto_decoder
#(
  parameter logic [11:0] PORT_ADDR  = 12'hf80,
  parameter logic [11:0] TIMER_ADDR = 12'hfd0
)
(
  // Clock and reset
  input  wire logic                          sys_clk,
  input  wire logic                          resetn,
  // Program memory
  input  wire logic [lto_pkg::WORD_W-1:0]    instr_word,
  output lto_pkg::lto_q_t                    q_phase,
  output logic                               second_cycle,
  // Data memory
  output logic [lto_pkg::ADDR_W-1:0]         file_rd_addr,
  input  wire logic [lto_pkg::DATA_W-1:0]    file_rd_data,
  output lto_pkg::lto_file_wr_t              file_wr,
  // Port pins
  input  wire logic [lto_pkg::DATA_W-1:0]    port_pins,
  // Timer, return and table side effects
  output logic                               timer_presc_clr,
  output logic                               return_strobe,
  output logic                               table_rd_strobe,
  output logic                               table_wr_strobe,
  output logic [lto_pkg::TBL_W-1:0]          table_addr,
  // Core state
  output logic [lto_pkg::DATA_W-1:0]         working_register,
  output lto_pkg::lto_flags_t                status_flags,
  output logic [lto_pkg::BANK_W-1:0]         bank_selection_register,
  output logic [lto_pkg::PROD_W-1:0]         product,
  // Register port
  input  wire lto_pkg::lto_bus_req_t         bus_req,
  output logic [lto_pkg::BUS_DW-1:0]         bus_rdata
);
  import lto_pkg::*;
  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  lto_q_t              q_reg, q_next;
  lto_cyc_t            cyc_reg, cyc_next;
  logic [WORD_W-1:0]   ir_reg, word2_reg;
  logic [DATA_W-1:0]   pin_meta_reg, pin_sync_reg;
  logic [ADDR_W-1:0]   file_addr_reg;
  logic [DATA_W-1:0]   opnd_reg, res_reg;
  lto_flags_t          flag_res_reg;
  logic [PROD_W-1:0]   prod_res_reg;
  logic [DATA_W-1:0]   w_reg;
  lto_flags_t          status_reg;
  logic [BANK_W-1:0]   bank_reg;
  logic [PROD_W-1:0]   prod_reg;
  logic [ADDR_W-1:0]   fsr_reg [FSR_CNT];
  logic [TBL_W-1:0]    tblptr_reg, table_addr_reg;
  logic [1:0]          ctrl_reg;
  lto_file_wr_t        file_wr_reg;
  logic                presc_clr_reg, ret_reg, tbl_rd_reg, tbl_wr_reg;
  logic [BUS_DW-1:0]   rdata_reg;

  // ---------------------------------------------------------------
  // Decode of the latched word
  // ---------------------------------------------------------------
  wire logic [7:0] hi_byte      = ir_reg[15:8];
  wire logic [7:0] lit          = ir_reg[7:0];
  wire logic       is_add_lit   = hi_byte == OPC_ADD_LIT;
  wire logic       is_and_lit   = hi_byte == OPC_AND_LIT;
  wire logic       is_or_lit    = hi_byte == OPC_OR_LIT;
  wire logic       is_xor_lit   = hi_byte == OPC_XOR_LIT;
  wire logic       is_sub_lit   = hi_byte == OPC_SUB_LIT;
  wire logic       is_load_lit  = hi_byte == OPC_LOAD_LIT;
  wire logic       is_mul_lit   = hi_byte == OPC_MUL_LIT;
  wire logic       is_ret_lit   = hi_byte == OPC_RET_LIT;
  wire logic       is_bank_load = ir_reg[15:4] == OPC_BANK_HI;
  wire logic       is_table     = (ir_reg[15:4] == OPC_TABLE_HI) && ir_reg[3];
  wire logic       is_tbl_write = is_table && ir_reg[2];
  wire logic [1:0] tbl_mode     = ir_reg[1:0];
  wire logic       is_ptr_load  = ir_reg[15:6] == OPC_PTR_HI;
  wire logic [1:0] ptr_sel      = ir_reg[5:4];
  wire logic       is_add_w_file_op     = ir_reg[15:10] == OPC_ADD_W_FILE_OP_HI;
  wire logic       dest_file    = ir_reg[9];
  wire logic       is_logic     = is_and_lit | is_or_lit | is_xor_lit;
  wire logic       is_arith     = is_add_lit | is_sub_lit | is_add_w_file_op;
  wire logic       two_cycle    = is_ret_lit | is_table | is_ptr_load;
  wire logic       first        = cyc_reg == LTO_CYC_FIRST;
  wire logic       ext_en       = ctrl_reg[CTRL_EXT_BIT];
  wire logic       psa_tmr      = ctrl_reg[CTRL_PSA_BIT];

  // ---------------------------------------------------------------
  // Operand address of the incoming word
  // ---------------------------------------------------------------
  wire logic [7:0]        in_f       = instr_word[7:0];
  wire logic              in_a       = instr_word[8];
  wire logic              in_indexed = !in_a && ext_en && (in_f <= INDEX_LIMIT);
  wire logic [ADDR_W-1:0] in_index   = fsr_reg[INDEX_PTR] + {4'h0, in_f};
  wire logic [ADDR_W-1:0] in_access  = (in_f < ACCESS_SPLIT) ? {4'h0, in_f} : {ACCESS_HIGH, in_f};
  wire logic [ADDR_W-1:0] in_addr    = in_a ? {bank_reg, in_f} :          // RULE14
                                       (in_indexed ? in_index : in_access); // RULE15
  wire logic              port_hit   = file_addr_reg == PORT_ADDR;

  // ---------------------------------------------------------------
  // Arithmetic and logic
  // ---------------------------------------------------------------
  wire logic [7:0] alu_a    = is_sub_lit ? lit : w_reg;
  wire logic [7:0] alu_b    = is_sub_lit ? ~w_reg : (is_add_w_file_op ? opnd_reg : lit);
  wire logic       alu_cin  = is_sub_lit;
  wire logic [8:0] sum9     = {1'b0, alu_a} + {1'b0, alu_b} + {8'h00, alu_cin};
  wire logic [4:0] nib5     = {1'b0, alu_a[3:0]} + {1'b0, alu_b[3:0]} + {4'h0, alu_cin};
  wire logic       ovf      = (alu_a[7] == alu_b[7]) && (sum9[7] != alu_a[7]);
  wire logic [7:0] log_res  = is_and_lit ? (w_reg & lit) :
                              (is_or_lit ? (w_reg | lit) : (w_reg ^ lit));
  wire logic [7:0] alu_res  = is_arith ? sum9[7:0] : (is_logic ? log_res : lit);
  wire lto_flags_t arith_fl = '{n: sum9[7], ov: ovf, z: sum9[7:0] == 8'h00, dc: nib5[4], c: sum9[8]};
  wire lto_flags_t logic_fl = '{n: log_res[7], ov: status_reg.ov, z: log_res == 8'h00,
                                dc: status_reg.dc, c: status_reg.c};
  wire lto_flags_t flags_nx = is_arith ? arith_fl : (is_logic ? logic_fl : status_reg);
  wire logic [15:0] prod_nx = 16'(lit) * 16'(w_reg);

  // ---------------------------------------------------------------
  // Table pointer
  // ---------------------------------------------------------------
  wire logic [TBL_W-1:0] tbl_inc    = tblptr_reg + 22'h1;
  wire logic [TBL_W-1:0] tbl_dec    = tblptr_reg - 22'h1;
  wire logic [TBL_W-1:0] tbl_access = (tbl_mode == TBL_PRE_INC) ? tbl_inc : tblptr_reg;
  wire logic [TBL_W-1:0] tbl_after  = (tbl_mode == TBL_PLAIN) ? tblptr_reg :
                                      ((tbl_mode == TBL_POST_DEC) ? tbl_dec : tbl_inc);

  // ---------------------------------------------------------------
  // Phase and cycle sequencing
  // ---------------------------------------------------------------
  wire logic q1 = q_reg == LTO_Q1;
  wire logic q2 = q_reg == LTO_Q2;
  wire logic q3 = q_reg == LTO_Q3;
  wire logic q4 = q_reg == LTO_Q4;
  always_comb
  begin
    case (q_reg)
      LTO_Q1:  q_next = LTO_Q2;
      LTO_Q2:  q_next = LTO_Q3;
      LTO_Q3:  q_next = LTO_Q4;
      default: q_next = LTO_Q1;
    endcase
  end
  // Second cycle of a flow change or table op is a no-operation; a pointer load writes its pointer at Q4 of it
  always_comb
  begin
    cyc_next = cyc_reg;
    if (q4)
      cyc_next = (first && two_cycle) ? LTO_CYC_SECOND : LTO_CYC_FIRST; // RULE17 RULE9 RULE10 RULE11 RULE12
  end

  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      q_reg   <= LTO_Q1;
      cyc_reg <= LTO_CYC_FIRST;
    end
    else
    begin
      q_reg   <= q_next;
      cyc_reg <= cyc_next;
    end
  end

  // ---------------------------------------------------------------
  // Pin synchroniser
  // ---------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      pin_meta_reg <= 8'h00;
      pin_sync_reg <= 8'h00;
    end
    else
    begin
      pin_meta_reg <= port_pins;
      pin_sync_reg <= pin_meta_reg;
    end
  end

  // ---------------------------------------------------------------
  // Q1 decode, Q2 read, Q3 process
  // ---------------------------------------------------------------
  // A lone 1111 word decodes as nothing; only the pointer load keeps it
  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      ir_reg        <= 16'h0000;
      word2_reg     <= 16'h0000;
      file_addr_reg <= 12'h000;
      opnd_reg      <= 8'h00;
      res_reg       <= 8'h00;
      flag_res_reg  <= '0;
      prod_res_reg  <= 16'h0000;
    end
    else
    begin
      if (q1 && first)
      begin
        ir_reg        <= instr_word;                                    // RULE16 RULE18
        file_addr_reg <= in_addr;                                       // RULE14 RULE15
      end
      if (q1 && !first)
        word2_reg <= instr_word;                                        // RULE18
      if (q2)
        opnd_reg <= port_hit ? pin_sync_reg : file_rd_data;             // RULE16 RULE19
      if (q3)
      begin
        res_reg      <= alu_res;                                        // RULE16
        flag_res_reg <= flags_nx;
        prod_res_reg <= prod_nx;
      end
    end
  end

  // ---------------------------------------------------------------
  // Q4 destination writes
  // ---------------------------------------------------------------
  wire logic commit     = q4 && first;
  wire logic is_arith_w = is_add_lit | is_sub_lit | (is_add_w_file_op && !dest_file);
  wire logic w_dest     = is_arith_w | is_logic | is_load_lit | is_ret_lit;
  wire logic ptr_done   = q4 && !first && is_ptr_load && (ptr_sel < 2'(FSR_CNT));
  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      w_reg      <= W_RST;
      status_reg <= '0;
      bank_reg   <= BANK_RST;
      prod_reg   <= 16'h0000;
    end
    else if (commit)
    begin
      if (w_dest)
        w_reg <= res_reg;                                               // RULE1 RULE2 RULE3 RULE4 RULE5 RULE6 RULE9 RULE13
      if (is_arith || is_logic)
        status_reg <= flag_res_reg;                                     // RULE1 RULE5 RULE13
      if (is_bank_load)
        bank_reg <= lit[3:0];                                           // RULE7
      if (is_mul_lit)
        prod_reg <= prod_res_reg;                                       // RULE8
    end
  end

  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      for (int i = 0; i < FSR_CNT; i++)
        fsr_reg[i] <= 12'h000;
    end
    else if (ptr_done)
      fsr_reg[ptr_sel] <= {ir_reg[3:0], word2_reg[7:0]};                // RULE10
  end
  // Strobes are set at Q3 so that they stand exactly through Q4
  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      file_wr_reg    <= '0;
      presc_clr_reg  <= 1'b0;
      ret_reg        <= 1'b0;
      tbl_rd_reg     <= 1'b0;
      tbl_wr_reg     <= 1'b0;
      table_addr_reg <= 22'h000000;
    end
    else
    begin
      file_wr_reg.en   <= q3 && first && is_add_w_file_op && dest_file;         // RULE13 RULE16
      file_wr_reg.addr <= file_addr_reg;
      file_wr_reg.data <= alu_res;
      presc_clr_reg    <= q3 && first && is_add_w_file_op && dest_file
                          && (file_addr_reg == TIMER_ADDR) && psa_tmr;  // RULE20
      ret_reg          <= q3 && first && is_ret_lit;                    // RULE9
      tbl_rd_reg       <= q3 && first && is_table && !is_tbl_write;     // RULE11
      tbl_wr_reg       <= q3 && first && is_tbl_write;                  // RULE12
      if (q3 && first && is_table)
        table_addr_reg <= tbl_access;
    end
  end

  // ---------------------------------------------------------------
  // Register port
  // ---------------------------------------------------------------
  wire logic wr_ctrl = bus_req.wr && (bus_req.addr == REG_CTRL);
  wire logic wr_tbl  = bus_req.wr && (bus_req.addr == REG_TBLPTR);
  wire logic [BUS_DW-1:0] rd_mux =
    (bus_req.addr == REG_CTRL)   ? {30'h0, ctrl_reg} :
    (bus_req.addr == REG_W)      ? {24'h0, w_reg} :
    (bus_req.addr == REG_STATUS) ? {27'h0, status_reg} :
    (bus_req.addr == REG_BANK)   ? {28'h0, bank_reg} :
    (bus_req.addr == REG_PROD)   ? {16'h0, prod_reg} :
    (bus_req.addr == REG_FSR0)   ? {20'h0, fsr_reg[0]} :
    (bus_req.addr == REG_FSR1)   ? {20'h0, fsr_reg[1]} :
    (bus_req.addr == REG_FSR2)   ? {20'h0, fsr_reg[2]} :
    (bus_req.addr == REG_TBLPTR) ? {10'h0, tblptr_reg} : 32'h0;
  // Table update at Q4 wins over a software write in the same clock
  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      ctrl_reg   <= CTRL_RST;
      tblptr_reg <= 22'h000000;
      rdata_reg  <= 32'h0;
    end
    else
    begin
      if (wr_ctrl)
        ctrl_reg <= bus_req.wdata[1:0];
      if (commit && is_table)
        tblptr_reg <= tbl_after;                                        // RULE11 RULE12
      else if (wr_tbl)
        tblptr_reg <= bus_req.wdata[TBL_W-1:0];
      rdata_reg <= bus_req.rd ? rd_mux : 32'h0;
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  assign q_phase                 = q_reg;
  assign second_cycle            = cyc_reg;
  assign file_rd_addr            = file_addr_reg;
  assign file_wr                 = file_wr_reg;
  assign timer_presc_clr         = presc_clr_reg;
  assign return_strobe           = ret_reg;
  assign table_rd_strobe         = tbl_rd_reg;
  assign table_wr_strobe         = tbl_wr_reg;
  assign table_addr              = table_addr_reg;
  assign working_register        = w_reg;
  assign status_flags            = status_reg;
  assign bank_selection_register = bank_reg;
  assign product                 = prod_reg;
  assign bus_rdata               = rdata_reg;
  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!resetn);
  phase_order_a: assert property (q4 |=> q1 ##1 q2 ##1 q3 ##1 q4) else $error("phase sequence broken"); // RULE16
  add_lit_a: assert property (commit && is_add_lit |=> // RULE1
    w_reg == 8'($past(w_reg) + $past(lit)) && status_flags.c == ($past({1'b0, w_reg}) + $past({1'b0, lit}) > 9'hff))
    else $error("add literal result wrong");
  and_lit_a: assert property (commit && is_and_lit |=> // RULE2
    w_reg == ($past(w_reg) & $past(lit)) && status_reg.c == $past(status_reg.c) && status_reg.z == (w_reg == 8'h00))
    else $error("and literal result wrong");
  or_lit_a: assert property (commit && is_or_lit |=> w_reg == ($past(w_reg) | $past(lit)) && $stable(status_reg.dc)) // RULE3
    else $error("or literal result wrong");
  xor_lit_a: assert property (commit && is_xor_lit |=> w_reg == ($past(w_reg) ^ $past(lit)) && $stable(status_reg.ov)) // RULE4
    else $error("xor literal result wrong");
  sub_lit_a: assert property (commit && is_sub_lit |=> w_reg == 8'($past(lit) - $past(w_reg))) // RULE5
    else $error("literal minus w wrong");
  load_lit_a: assert property (commit && is_load_lit |=> w_reg == $past(lit) && $stable(status_reg)) // RULE6
    else $error("load literal wrong");
  bank_load_a: assert property (commit && is_bank_load |=> bank_reg == $past(lit[3:0]) && $stable(status_reg)) // RULE7
    else $error("bank load wrong");
  mul_lit_a: assert property (commit && is_mul_lit |=> prod_reg == 16'($past(lit)) * 16'($past(w_reg))) // RULE8
    else $error("multiply wrong");
  ret_two_a: assert property (commit && is_ret_lit |=> !first [*4] ##1 first) // RULE9
    else $error("return not two cycles");
  ptr_load_a: assert property (ptr_done |=> fsr_reg[$past(ptr_sel)] == {$past(ir_reg[3:0]), $past(word2_reg[7:0])}) // RULE10
    else $error("pointer load wrong");
  tbl_read_a: assert property (table_rd_strobe |-> q4 && first && $stable(status_reg)) // RULE11
    else $error("table read strobe misplaced");
  file_write_a: assert property (file_wr.en |-> q4 && first && is_add_w_file_op && dest_file) // RULE13
    else $error("file write misplaced");
  presc_clr_a: assert property (timer_presc_clr |-> file_wr.en && file_wr.addr == TIMER_ADDR) // RULE20
    else $error("prescaler clear without timer write");
endmodule

// ==== testbench/lto_decoder_tb_top.sv ====
// Purpose: Self-checking bench for the literal, table and add-W-to-file decoder
// Assumes: Each op and bus call spans one four-clock instruction cycle; chk and results take no time
// Notes:   Data memory returns address low byte xor 5ah; pins held at 3ch
`timescale 1ns/1ps

module lto_decoder_tb_top;
  import lto_pkg::*;

  logic                 sys_clk = 1'b0;
  logic                 resetn  = 1'b0;
  logic [WORD_W-1:0]    instr_word = '0;
  lto_q_t               q_phase;
  logic                 second_cycle, timer_presc_clr, return_strobe, table_rd_strobe, table_wr_strobe;
  logic [ADDR_W-1:0]    file_rd_addr;
  logic [DATA_W-1:0]    file_rd_data, working_register;
  lto_file_wr_t         file_wr, fw;
  logic [TBL_W-1:0]     table_addr, ta;
  lto_flags_t           status_flags;
  logic [BANK_W-1:0]    bank_selection_register;
  logic [PROD_W-1:0]    product;
  lto_bus_req_t         bus_req = '0;
  logic [BUS_DW-1:0]    bus_rdata, got;
  logic                 s_ret, s_trd, s_twr, s_tpc, s_2nd;
  int                   num_errors = 0;
  int                   checked    = 0;

  always #12.5 sys_clk = ~sys_clk;
  assign file_rd_data = file_rd_addr[7:0] ^ 8'h5a;

  lto_decoder lto_decoder_i (.sys_clk(sys_clk), .resetn(resetn), .instr_word(instr_word), .q_phase(q_phase),
    .second_cycle(second_cycle), .file_rd_addr(file_rd_addr), .file_rd_data(file_rd_data), .file_wr(file_wr),
    .port_pins(8'h3c), .timer_presc_clr(timer_presc_clr), .return_strobe(return_strobe),
    .table_rd_strobe(table_rd_strobe), .table_wr_strobe(table_wr_strobe), .table_addr(table_addr),
    .working_register(working_register), .status_flags(status_flags),
    .bank_selection_register(bank_selection_register), .product(product), .bus_req(bus_req), .bus_rdata(bus_rdata));

  // ---------------------------------------------------------------
  // Tasks
  // ---------------------------------------------------------------
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checked++;
    if (g !== e)
    begin
      num_errors++;
      $display("ERROR at %0t: got %h expected %h", $time, g, e);
    end
  endtask

  // One instruction cycle; side-effect pulses are collected sticky
  task automatic op(input logic [15:0] w);
    instr_word <= w;
    repeat (4)
    begin
      @(posedge sys_clk);
      #1;
      s_ret |= return_strobe;
      s_trd |= table_rd_strobe;
      s_twr |= table_wr_strobe;
      s_tpc |= timer_presc_clr;
      s_2nd |= second_cycle;
      if (file_wr.en === 1'b1) fw = file_wr;
      if ((table_rd_strobe | table_wr_strobe) === 1'b1) ta = table_addr;
    end
  endtask

  // Bus access padded with a no-operation word to keep the phase
  task automatic bus(input logic [7:0] a, input logic [31:0] d, input logic w);
    instr_word <= '0;
    bus_req <= '{a, d, w, ~w};
    @(posedge sys_clk);
    bus_req <= '0;
    #1 got = bus_rdata;
    repeat (3) @(posedge sys_clk);
  endtask

  task automatic results();
    $display("comparisons %0d mismatches %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial
  begin
    {s_ret, s_trd, s_twr, s_tpc, s_2nd} = '0;
    repeat (20) @(posedge sys_clk);
    resetn <= 1'b1;
    op(16'h0e10); chk(working_register, 8'h10);
    op(16'h0ff0); chk(working_register, 8'h00); chk(status_flags, 5'h05);
    op(16'h0b0a); chk(working_register, 8'h00); chk(status_flags, 5'h05);
    op(16'h0980); chk(working_register, 8'h80); chk(status_flags, 5'h11);
    op(16'h0a80); chk(working_register, 8'h00); chk(status_flags, 5'h05);
    op(16'h0801); chk(working_register, 8'h01); chk(status_flags, 5'h03);
    op(16'h0e02); op(16'h0801); chk(working_register, 8'hff); chk(status_flags, 5'h10);
    op(16'h0e7f); op(16'h0f01); chk(working_register, 8'h80); chk(status_flags, 5'h1a);
    op(16'h0d03); chk(product, 16'h0180); chk(status_flags, 5'h1a);
    op(16'h0105); chk(bank_selection_register, 4'h5);
    $display("test literal done");
    op(16'h0c44); chk(s_ret, 1'b1);
    op(16'h0e99); chk(working_register, 8'h44); chk(s_2nd, 1'b1);
    op(16'hee20); op(16'hf0ab); bus(REG_FSR2, '0, 1'b0); chk(got, 32'h0ab);
    op(16'hf0ff); chk(working_register, 8'h44);
    $display("test two-cycle done");
    bus(REG_TBLPTR, 32'h100, 1'b1); op(16'h0009); op(16'h0000); chk({s_trd, ta}, {1'b1, 22'h100});
    bus(REG_TBLPTR, '0, 1'b0); chk(got, 32'h101);
    op(16'h000f); op(16'h0000); chk({s_twr, ta}, {1'b1, 22'h102});
    $display("test table done");
    op(16'h2730); chk(fw, {1'b1, 12'h530, 8'hae}); chk(status_flags, 5'h18);
    op(16'h2470); chk(working_register, 8'h6e);
    bus(REG_CTRL, 32'h1, 1'b1); op(16'h2410); chk(working_register, 8'h4f);
    bus(REG_CTRL, 32'h3, 1'b1); op(16'h26d0); chk({s_tpc, fw.addr}, {1'b1, 12'hfd0});
    op(16'h2480); chk(working_register, 8'h8b);
    bus(REG_W, 32'h11, 1'b1); bus(REG_W, '0, 1'b0); chk(got, 32'h8b);
    bus(8'h40, '0, 1'b0); chk(got, 32'h0);
    $display("test file done");
    results();
  end
endmodule
